// [design/cct_pkg.sv]
// constants for the capture/compare timer block
package cct_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] ADDR_TMR_LO  = 8'h00; // timer_count_low
	localparam logic [7:0] ADDR_TMR_HI  = 8'h04; // timer_count_high
	localparam logic [7:0] ADDR_TCTL    = 8'h08; // timer_control_register
	localparam logic [7:0] ADDR_CC_LO   = 8'h0C; // capture_compare low byte
	localparam logic [7:0] ADDR_CC_HI   = 8'h10; // capture_compare high byte
	localparam logic [7:0] ADDR_UCTL    = 8'h14; // unit_control_register
	localparam logic [7:0] ADDR_FLAG    = 8'h18; // peripheral_flag_register
	localparam logic [7:0] ADDR_ENA     = 8'h1C; // peripheral_enable_register
	localparam logic [7:0] ADDR_DIR     = 8'h20; // port_c_direction
	localparam logic [7:0] ADDR_PDAT    = 8'h24; // port c data latch
	// timer_control_register bits
	localparam int TCTL_ON      = 0; // timer runs
	localparam int TCTL_EXT     = 1; // count external clock pin
	localparam int TCTL_NOSYNC  = 2; // timer_sync_disable
	localparam int TCTL_OSC     = 3; // timer_osc_enable
	// flag / enable bits
	localparam int FLAG_OVF     = 0; // timer overflow
	localparam int FLAG_UNIT    = 2; // unit_irq_flag
	localparam int PIN_BIT      = 2; // port c bit of the unit pin
	// unit_mode_field codes
	localparam logic [3:0] MODE_OFF   = 4'h0;
	localparam logic [3:0] CAP_FALL   = 4'h4;
	localparam logic [3:0] CAP_RISE   = 4'h5;
	localparam logic [3:0] CAP_DIV4   = 4'h6;
	localparam logic [3:0] CAP_DIV16  = 4'h7;
	localparam logic [3:0] CMP_HIGH   = 4'h8;
	localparam logic [3:0] CMP_LOW    = 4'h9;
	// last prescaler counts before a capture
	localparam logic [3:0] DIV4_LAST  = 4'h3;
	localparam logic [3:0] DIV16_LAST = 4'hF;
	// reset values
	localparam logic [7:0] DIR_RESET  = 8'hFF; // all pins input
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [design/cct_top.sv]
// capture/compare unit with 16-bit timer behind an AXI4-Lite slave
// Functional notes
// - capture copies full timer into pair
// - mode picks fall, rise, 4th, 16th rise
// - capture sets unit flag until cleared
// - new capture overwrites unread old value
// - output pin write can cause capture
// - mode change may give spurious interrupt
// - prescaler cleared when off, non-capture, reset
// - prescaler switch keeps count, may interrupt
// - compare match drives pin high/low/unchanged
// - compare flag set with pin action
// - clearing control forces compare latch low
// - sync-disable still syncs count clock, overflow wakes
// - async timer not a capture/compare base
// - timer byte reads always return valid value
// - oscillator enable starts low-power oscillator
`timescale 1ns/1ps
module cct_top
	import cct_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        capture_compare_pin_i,
	output logic             capture_compare_pin_o,
	output logic             capture_compare_pin_oe_n,
	input  wire logic        timer_ext_clk_i,
	output logic             timer_osc_enable_o,
	output logic             unit_irq_o,
	output logic             timer_wake_o
);
	// address match, shared by the read and write decoders
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction
	// any register: word aligned and inside the map
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= ADDR_PDAT);
	endfunction
	// bus slave state
	logic        aw_free_q;    // doubles as awready
	logic        w_free_q;     // doubles as wready
	logic [7:0]  aw_addr_q;    // held write address
	logic [7:0]  w_data_q;     // held low byte of write data
	logic        w_lane_q;     // low byte lane enabled
	logic        bvalid_q;     // write answer pending
	logic [1:0]  bresp_q;      // write answer code
	logic        ar_free_q;    // doubles as arready
	logic        rvalid_q;     // read answer pending
	logic [1:0]  rresp_q;      // read answer code
	logic [31:0] rdata_q;      // read answer data
	// block state
	logic [15:0] timer_q;      // timer_count_pair
	logic [7:0]  tctl_q;       // timer_control_register
	logic [15:0] cc_q;         // capture_compare_register
	logic [3:0]  mode_q;       // unit_mode_field
	logic [7:0]  flag_q;       // peripheral_flag_register
	logic [7:0]  ena_q;        // peripheral_enable_register
	logic [7:0]  dir_q;        // port_c_direction
	logic [7:0]  pdat_q;       // port c data latch
	logic        cmp_latch_q;  // compare output latch
	logic [3:0]  pre_q;        // capture prescaler counter
	logic        src_prev_q;   // last capture source sample
	logic        eq_prev_q;    // compare equality last cycle
	logic [1:0]  pin_sync_q;   // pin synchroniser
	logic [1:0]  ext_sync_q;   // external count clock synchroniser
	logic        ext_prev_q;   // last synced count clock
	logic        pin_o_q, pin_oe_n_q;     // registered pin drive
	logic        irq_q, wake_q, osc_q;    // registered status lines
	// bus decode
	wire wr_go = !aw_free_q && !w_free_q && !bvalid_q;
	wire rd_go = s_axi_arvalid && ar_free_q;
	wire wr_lo = wr_go && w_lane_q;
	wire w_tlo  = wr_lo && hit(aw_addr_q, ADDR_TMR_LO);
	wire w_thi  = wr_lo && hit(aw_addr_q, ADDR_TMR_HI);
	wire w_tctl = wr_lo && hit(aw_addr_q, ADDR_TCTL);
	wire w_clo  = wr_lo && hit(aw_addr_q, ADDR_CC_LO);
	wire w_chi  = wr_lo && hit(aw_addr_q, ADDR_CC_HI);
	wire w_uctl = wr_lo && hit(aw_addr_q, ADDR_UCTL);
	wire w_flag = wr_lo && hit(aw_addr_q, ADDR_FLAG);
	wire w_ena  = wr_lo && hit(aw_addr_q, ADDR_ENA);
	wire w_dir  = wr_lo && hit(aw_addr_q, ADDR_DIR);
	wire w_pdat = wr_lo && hit(aw_addr_q, ADDR_PDAT);
	wire aw_map = mapped(aw_addr_q);
	// read mux; bytes sit in the low lane, upper bits read zero
	wire [7:0] ra = s_axi_araddr;
	wire [7:0] rd_byte =
		hit(ra, ADDR_TMR_LO) ? timer_q[7:0] :
		hit(ra, ADDR_TMR_HI) ? timer_q[15:8] :
		hit(ra, ADDR_TCTL)   ? tctl_q :
		hit(ra, ADDR_CC_LO)  ? cc_q[7:0] :
		hit(ra, ADDR_CC_HI)  ? cc_q[15:8] :
		hit(ra, ADDR_UCTL)   ? {4'h0, mode_q} :
		hit(ra, ADDR_FLAG)   ? flag_q :
		hit(ra, ADDR_ENA)    ? ena_q :
		hit(ra, ADDR_DIR)    ? dir_q :
		hit(ra, ADDR_PDAT)   ? pdat_q : ZERO_BYTE;
	wire rd_map = mapped(ra);
	// mode decode
	wire [3:0] mode_d = w_uctl ? w_data_q[3:0] : mode_q;
	wire is_cap  = (mode_q[3:2] == 2'b01);
	wire is_cmp  = mode_q[3];
	wire cap_nxt = (mode_d[3:2] == 2'b01);
	// timer clocking; async mode counts the raw synced edge but
	// is then no time base for the unit
	wire ext_rise = ext_sync_q[1] && !ext_prev_q;
	wire async_m  = tctl_q[TCTL_EXT] && tctl_q[TCTL_NOSYNC];
	wire base_ok  = !async_m;
	wire tick = tctl_q[TCTL_ON] && (tctl_q[TCTL_EXT] ? ext_rise : 1'b1);
	wire ovf  = tick && (timer_q == 16'hFFFF);
	wire [15:0] timer_inc = tick ? timer_q + 16'h0001 : timer_q;
	// a bus write wins over a coinciding increment
	wire [15:0] timer_d = {w_thi ? w_data_q : timer_inc[15:8],
		w_tlo ? w_data_q : timer_inc[7:0]};
	// capture source: pin when input, own drive when output
	wire src = dir_q[PIN_BIT] ? pin_sync_q[1] : pin_o_q;
	wire fall = src_prev_q && !src;
	wire rise = !src_prev_q && src;
	wire pre_hit = (mode_q == CAP_DIV4) ? (pre_q == DIV4_LAST)
		: (pre_q == DIV16_LAST);
	wire cap_ev = is_cap && base_ok && (
		(mode_q == CAP_FALL) ? fall :
		(mode_q == CAP_RISE) ? rise : (rise && pre_hit));
	// prescaler: cleared off/out of capture, kept across capture modes
	wire [3:0] pre_d = (!cap_nxt) ? 4'h0 :
		(is_cap && rise && mode_q[1]) ?
			(pre_hit ? 4'h0 : pre_q + 4'h1) : pre_q;
	// compare match fires once on entering equality
	wire eq = (cc_q == timer_q) && base_ok;
	wire cmp_ev = is_cmp && eq && !eq_prev_q;
	wire cmp_latch_d =
		(w_uctl && w_data_q[3:0] == MODE_OFF) ? 1'b0 :
		(cmp_ev && mode_q == CMP_HIGH) ? 1'b1 :
		(cmp_ev && mode_q == CMP_LOW)  ? 1'b0 : cmp_latch_q;
	wire [7:0] pdat_d = w_pdat ? w_data_q : pdat_q;
	wire [7:0] dir_d  = w_dir ? w_data_q : dir_q;
	wire pin_o_d = mode_d[3] ? cmp_latch_d : pdat_d[PIN_BIT];
	// flags: hardware set wins over a software clear (write 0)
	wire [7:0] flag_set = {5'h0, cap_ev || cmp_ev, 1'b0, ovf};
	wire [7:0] flag_keep = w_flag ? (flag_q & w_data_q) : flag_q;
	wire [7:0] flag_d = flag_keep | flag_set;
	wire [7:0] ena_d  = w_ena ? w_data_q : ena_q;
	wire [7:0] tctl_d = w_tctl ? w_data_q : tctl_q;
	// write address and data channels, taken in either order
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			aw_free_q <= 1'b1;
			w_free_q  <= 1'b1;
			aw_addr_q <= ZERO_BYTE;
			w_data_q  <= ZERO_BYTE;
			w_lane_q  <= 1'b0;
		end
		else
		begin
			// hold address until the answer is taken
			if (s_axi_awvalid && aw_free_q)
			begin
				aw_free_q <= 1'b0;
				aw_addr_q <= s_axi_awaddr;
			end
			else if (s_axi_bvalid && s_axi_bready)
				aw_free_q <= 1'b1;
			// hold data likewise
			if (s_axi_wvalid && w_free_q)
			begin
				w_free_q <= 1'b0;
				w_data_q <= s_axi_wdata[7:0];
				w_lane_q <= s_axi_wstrb[0];
			end
			else if (s_axi_bvalid && s_axi_bready)
				w_free_q <= 1'b1;
		end
	end
	// write answer, one cycle after both halves are held
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= aw_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end
	// read channel, answer one cycle after the address is taken
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ar_free_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end
		else if (rd_go)
		begin
			ar_free_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= rd_map ? RESP_OKAY : RESP_SLVERR;
			rdata_q   <= {24'h00_0000, rd_byte};
		end
		else if (rvalid_q && s_axi_rready)
		begin
			ar_free_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end
	// pin and count clock synchronisers
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pin_sync_q <= 2'b00;
			ext_sync_q <= 2'b00;
			ext_prev_q <= 1'b0;
		end
		else
		begin
			pin_sync_q <= {pin_sync_q[0], capture_compare_pin_i};
			ext_sync_q <= {ext_sync_q[0], timer_ext_clk_i};
			ext_prev_q <= ext_sync_q[1];
		end
	end
	// timer, control and capture/compare pair
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			timer_q <= 16'h0000;
			tctl_q  <= ZERO_BYTE;
			cc_q    <= 16'h0000;
			mode_q  <= MODE_OFF;
		end
		else
		begin
			timer_q <= timer_d;
			tctl_q  <= tctl_d;
			mode_q  <= mode_d;
			// capture overwrites any unread value
			if (cap_ev)
				cc_q <= timer_q;
			else
			begin
				if (w_clo)
					cc_q[7:0] <= w_data_q;
				if (w_chi)
					cc_q[15:8] <= w_data_q;
			end
		end
	end
	// unit state, flags and registered outputs
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pre_q       <= 4'h0;
			src_prev_q  <= 1'b0;
			eq_prev_q   <= 1'b0;
			cmp_latch_q <= 1'b0;
			flag_q      <= ZERO_BYTE;
			ena_q       <= ZERO_BYTE;
			dir_q       <= DIR_RESET;
			pdat_q      <= ZERO_BYTE;
			pin_o_q     <= 1'b0;
			pin_oe_n_q  <= 1'b1;
			irq_q       <= 1'b0;
			wake_q      <= 1'b0;
			osc_q       <= 1'b0;
		end
		else
		begin
			pre_q       <= pre_d;
			src_prev_q  <= src;
			eq_prev_q   <= eq;
			cmp_latch_q <= cmp_latch_d;
			flag_q      <= flag_d;
			ena_q       <= ena_d;
			dir_q       <= dir_d;
			pdat_q      <= pdat_d;
			// pin level and unit flag move on the same edge
			pin_o_q     <= pin_o_d;
			pin_oe_n_q  <= dir_d[PIN_BIT];
			// enable gates spurious mode-change flags off the line
			irq_q       <= flag_d[FLAG_UNIT] && ena_d[FLAG_UNIT];
			// overflow in async mode may wake the core
			wake_q      <= flag_d[FLAG_OVF] && ena_d[FLAG_OVF]
				&& tctl_d[TCTL_NOSYNC];
			osc_q       <= tctl_d[TCTL_OSC];
		end
	end
	// port drives
	assign s_axi_awready            = aw_free_q;
	assign s_axi_wready             = w_free_q;
	assign s_axi_bvalid             = bvalid_q;
	assign s_axi_bresp              = bresp_q;
	assign s_axi_arready            = ar_free_q;
	assign s_axi_rvalid             = rvalid_q;
	assign s_axi_rresp              = rresp_q;
	assign s_axi_rdata              = rdata_q;
	assign capture_compare_pin_o    = pin_o_q;
	assign capture_compare_pin_oe_n = pin_oe_n_q;
	assign timer_osc_enable_o       = osc_q;
	assign unit_irq_o               = irq_q;
	assign timer_wake_o             = wake_q;
endmodule

// [tb/capture_compare_timer_tb_top.sv]
// testbench: bus tasks and pin stimulus for the capture/compare unit
`timescale 1ns/1ps
module capture_compare_timer_tb_top;
	import cct_pkg::*;
	logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, timer_ext_clk_i;
	logic        capture_compare_pin_i, capture_compare_pin_o, timer_wake_o;
	logic        capture_compare_pin_oe_n, timer_osc_enable_o, unit_irq_o;
	logic        src_en, src_val;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rd_q;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
	int          mismatches, tests_run;
	logic [3:0]  cm [4] = '{CAP_FALL, CAP_RISE, CAP_DIV4, CAP_DIV16};
	int          cn [4] = '{0, 0, 3, 15};
	logic [3:0]  pm [4] = '{CMP_HIGH, 4'hA, CMP_LOW, CMP_HIGH};
	logic        pv [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
	cct_top dut (.*);
	cct_pin_model u_pin (.clk_sys(clk_sys), .pin_o(capture_compare_pin_o),
		.pin_oe_n(capture_compare_pin_oe_n), .src_en(src_en),
		.src_val(src_val), .pin_wire(capture_compare_pin_i));
	initial
	begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic complete_run();
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	// write one byte register, hold each channel until taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		resp_q = s_axi_bresp;
	endtask
	// read one byte register
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rd_q = s_axi_rdata[7:0];
		resp_q = s_axi_rresp;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk8(rd_q, e);
	endtask
	task automatic md(input logic [3:0] m);
		wr(ADDR_UCTL, {4'h0, m});
	endtask
	// n full pin pulses, each a rise and a fall
	task automatic pulse(input int n);
		repeat (n)
		begin
			src_val <= 1'h1;
			repeat (4) @(posedge clk_sys);
			src_val <= 1'h0;
			repeat (4) @(posedge clk_sys);
		end
	endtask
	// set a mode, count events short of the trigger, then fire it
	task automatic run(input logic [3:0] m, input int n);
		md(m);
		wr(ADDR_FLAG, 8'h00);
		pulse(n);
		rdchk(ADDR_FLAG, 8'h00);
		pulse(1);
		rdchk(ADDR_FLAG, 8'h04);
	endtask
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		mismatches++;
		complete_run();
	end
	initial
	begin
		{mismatches, tests_run} = 64'h0;
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, timer_ext_clk_i, src_val} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		src_en = 1'h1;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		rdchk(ADDR_DIR, DIR_RESET);
		chk1(capture_compare_pin_oe_n, 1'h1);
		rd(8'h28);
		chk8({6'h00, resp_q}, {6'h00, RESP_SLVERR});
		chk8(rd_q, ZERO_BYTE);
		wr(8'h28, 8'h55);
		chk8({6'h00, resp_q}, {6'h00, RESP_SLVERR});
		wr(ADDR_TCTL, 8'h00);
		chk8({6'h00, resp_q}, {6'h00, RESP_OKAY});
		for (int i = 0; i < 4; i++)
		begin
			md(MODE_OFF);
			wr(ADDR_TMR_LO, 8'hA0 + i[7:0]);
			wr(ADDR_TMR_HI, 8'h10 + i[7:0]);
			run(cm[i], cn[i]);
			rdchk(ADDR_CC_LO, 8'hA0 + i[7:0]);
			rdchk(ADDR_CC_HI, 8'h10 + i[7:0]);
		end
		md(CAP_RISE);
		wr(ADDR_TMR_LO, 8'h5A);
		pulse(1);
		wr(ADDR_TMR_LO, 8'h6B);
		pulse(1);
		rdchk(ADDR_CC_LO, 8'h6B);
		md(CAP_DIV4);
		pulse(2);
		md(MODE_OFF);
		run(CAP_DIV4, 3);
		pulse(2);
		run(CAP_DIV16, 13);
		wr(ADDR_TCTL, 8'h0E);
		md(CAP_RISE);
		wr(ADDR_FLAG, 8'h00);
		pulse(1);
		rdchk(ADDR_FLAG, 8'h00);
		rdchk(ADDR_TCTL, 8'h0E);
		chk1(timer_osc_enable_o, 1'h1);
		wr(ADDR_ENA, 8'h01);
		wr(ADDR_TMR_LO, 8'hFF);
		wr(ADDR_TMR_HI, 8'hFF);
		wr(ADDR_TCTL, 8'h07);
		timer_ext_clk_i <= 1'h1;
		repeat (4) @(posedge clk_sys);
		chk1(timer_wake_o, 1'h1);
		rdchk(ADDR_FLAG, 8'h01);
		rdchk(ADDR_TMR_HI, 8'h00);
		rdchk(ADDR_TMR_LO, 8'h00);
		rdchk(ADDR_TMR_HI, 8'h00);
		timer_ext_clk_i <= 1'h0;
		wr(ADDR_TCTL, 8'h00);
		wr(ADDR_DIR, 8'hFB);
		chk1(capture_compare_pin_oe_n, 1'h0);
		src_en <= 1'h0;
		wr(ADDR_FLAG, 8'h00);
		wr(ADDR_PDAT, 8'h04);
		repeat (4) @(posedge clk_sys);
		rdchk(ADDR_FLAG, 8'h04);
		chk1(capture_compare_pin_o, 1'h1);
		wr(ADDR_CC_LO, 8'h10);
		wr(ADDR_CC_HI, 8'h00);
		wr(ADDR_ENA, 8'h04);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_TCTL, 8'h00);
			wr(ADDR_TMR_LO, 8'h00);
			wr(ADDR_TMR_HI, 8'h00);
			md(pm[i]);
			wr(ADDR_FLAG, 8'h00);
			wr(ADDR_TCTL, 8'h01);
			@(negedge clk_sys);
			while (!unit_irq_o) @(negedge clk_sys);
			chk1(capture_compare_pin_o, pv[i]);
			rdchk(ADDR_FLAG, 8'h04);
		end
		wr(ADDR_TCTL, 8'h00);
		md(MODE_OFF);
		md(4'hA);
		@(negedge clk_sys);
		chk1(capture_compare_pin_o, 1'h0);
		rdchk(ADDR_PDAT, 8'h04);
		complete_run();
	end
endmodule

// [tb/cct_pin_model.sv]
// external source and load sharing the unit pin
`timescale 1ns/1ps
module cct_pin_model (
	input  wire logic clk_sys,
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	input  wire logic src_en,
	input  wire logic src_val,
	output logic      pin_wire
);
	logic last_q; // last driven level on the wire
	// device drive first, then the source, else a floating level
	always_comb
	begin
		if (!pin_oe_n)
			pin_wire = pin_o;
		else if (src_en)
			pin_wire = src_val;
		else
			pin_wire = ~last_q;
	end
	// remember the last driven level; a float shows its inverse
	always_ff @(posedge clk_sys)
		if (!pin_oe_n || src_en)
			last_q <= pin_wire;
endmodule

// [tb/cct_top_chk.sv]
// checker for bus handshakes and sticky outputs of the unit
`timescale 1ns/1ps
module cct_top_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        timer_osc_enable_o,
	input wire logic        unit_irq_o
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// address and data taken at one edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// slots close, then the response shows
	sequence s_wr_answer;
		!s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endsequence
	property p_wr_walk;
		s_wr_take |=> s_wr_answer;
	endproperty
	a_wr_walk: assert property (p_wr_walk) else $error("write answer late");
	property p_b_cause;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	a_b_cause: assert property (p_b_cause) else $error("response unasked");
	property p_b_stand;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("response dropped");
	property p_b_release;
		s_axi_bvalid && s_axi_bready |=>
			!s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_b_release: assert property (p_b_release) else $error("write slot shut");
	property p_ar_r;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_ar_r: assert property (p_ar_r) else $error("read answer late");
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=>
			s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data moved");
	property p_r_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_r_upper: assert property (p_r_upper) else $error("upper bytes set");
	// the unit flag only drops through a register write
	property p_irq_sticky;
		$fell(unit_irq_o) |-> $rose(s_axi_bvalid);
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("irq lost");
	// oscillator enable moves on the edge where the write answer rises
	property p_osc_follow;
		$changed(timer_osc_enable_o) |-> $rose(s_axi_bvalid);
	endproperty
	a_osc_follow: assert property (p_osc_follow) else $error("osc moved");
endmodule
bind cct_top cct_top_chk u_chk (.*);
